// ===== port_aux_pkg.sv
/*
 * package for the port auxiliary block: register offsets, field layout, reset values
 * assumes an APB slave with 32-bit data, one aligned word per register
 */
package port_aux_pkg;

    localparam int          PIN_COUNT       = 6;
    localparam int          ANALOG_COUNT    = 8;
    localparam int          INPUT_ONLY_IDX  = 3;
    localparam int          WAKE_PIN_IDX    = 0;
    localparam int          ADDR_W          = 8;

    // byte addresses
    localparam logic [7:0]  OFS_ANALOG      = 8'h00;
    localparam logic [7:0]  OFS_PULLUP      = 8'h04;
    localparam logic [7:0]  OFS_CHANGE_EN   = 8'h08;
    localparam logic [7:0]  OFS_CONTROL     = 8'h0C;
    localparam logic [7:0]  OFS_PORT        = 8'h10;
    localparam logic [7:0]  OFS_STATUS      = 8'h14;

    // reset values and masks
    localparam logic [7:0]  ANALOG_RST      = 8'hFF;
    localparam logic [7:0]  PULLUP_RST      = 8'h37;
    localparam logic [7:0]  PULLUP_MASK     = 8'h37;
    localparam logic [7:0]  CHANGE_EN_RST   = 8'h00;
    localparam logic [7:0]  CHANGE_EN_MASK  = 8'h3F;
    localparam logic [7:0]  OSC_FORCE_MASK  = 8'h30;

    // control register fields
    localparam int          CTL_PULLUP_DIS  = 0;
    localparam int          CTL_WAKE_EN     = 1;
    localparam int          CTL_GIE         = 2;
    localparam int          CTL_FLAG        = 3;

    typedef struct packed {
        logic [PIN_COUNT-1:0] pin_in;
        logic [PIN_COUNT-1:0] dir_in;
    } pin_side_t;

endpackage

// ===== port_pullup_change_wake.sv
/*
 * weak pull-ups, analog select gating, change detect and low-power wake sink for a six-pin port
 * assumes pin inputs synchronous to pclk; port data/direction logic lives outside
 */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
module port_pullup_change_wake
    import port_aux_pkg::*;
(
    // apb
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [port_aux_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // power-on reset: the only reset that clears the last-read latch
    input  wire logic                        por_n,
    // configuration
    input  wire logic                        master_clear_mode,
    input  wire logic                        crystal_osc_mode,
    input  wire logic                        sleeping,
    // pins
    input  wire port_aux_pkg::pin_side_t     pins,
    output logic      [port_aux_pkg::PIN_COUNT-1:0] pullup_on,
    output logic      [port_aux_pkg::PIN_COUNT-1:0] digital_in_en,
    output logic      [port_aux_pkg::ANALOG_COUNT-1:0] analog_sel,
    output logic                             wake_sink_on,
    // interrupt side
    output logic                             change_irq,
    output logic                             wake_req
);
    import port_aux_pkg::*;

    initial begin
        if (PIN_COUNT != 6 || ANALOG_COUNT != 8)
            $error("port geometry must be six pins, eight channels");
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic                     wr_en;
    logic                     rd_en;
    logic                     port_access;
    logic [7:0]               analog_q;
    logic [7:0]               pullup_q;
    logic [7:0]               change_en_q;
    logic                     pullup_dis_q;
    logic                     wake_en_q;
    logic                     gie_q;
    logic                     flag_q;
    logic [PIN_COUNT-1:0]     last_read_q;
    logic [PIN_COUNT-1:0]     mismatch;
    logic [PIN_COUNT-1:0]     pin_digital;
    logic [7:0]               pullup_view;
    logic [7:0]               change_view;
    logic                     addr_ok;

    assign wr_en       = psel && penable && pwrite;
    assign rd_en       = psel && penable && !pwrite;
    assign port_access = psel && penable && (paddr == OFS_PORT);
    assign pready      = 1'b1;
    assign addr_ok     = (paddr == OFS_ANALOG) || (paddr == OFS_PULLUP) || (paddr == OFS_CHANGE_EN)
                      || (paddr == OFS_CONTROL) || (paddr == OFS_PORT) || (paddr == OFS_STATUS);
    assign pslverr     = psel && penable && !addr_ok;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_q <= ANALOG_RST;
        end else if (wr_en && paddr == OFS_ANALOG) begin
            analog_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_q <= PULLUP_RST;
        end else if (wr_en && paddr == OFS_PULLUP) begin
            pullup_q <= pwdata[7:0] & PULLUP_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_en_q <= CHANGE_EN_RST;
        end else if (wr_en && paddr == OFS_CHANGE_EN) begin
            change_en_q <= pwdata[7:0] & CHANGE_EN_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_dis_q <= 1'b1;
            wake_en_q    <= 1'b0;
            gie_q        <= 1'b0;
        end else if (wr_en && paddr == OFS_CONTROL) begin
            pullup_dis_q <= pwdata[CTL_PULLUP_DIS];
            wake_en_q    <= pwdata[CTL_WAKE_EN];
            gie_q        <= pwdata[CTL_GIE];
        end
    end

    // ------------------------------------------------------------
    // pull-ups and analog gating
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            assign pin_digital[g] = !analog_q[g];
            if (g == INPUT_ONLY_IDX) begin : g_io
                assign pullup_on[g] = master_clear_mode;
            end else begin : g_pu
                assign pullup_on[g] = pullup_q[g] && pins.dir_in[g] && !pullup_dis_q
                                   && pin_digital[g];
            end
            assign mismatch[g] = change_en_q[g] && pin_digital[g]
                              && (pins.pin_in[g] != last_read_q[g]);
        end
    endgenerate

    assign digital_in_en = pin_digital;
    assign analog_sel    = analog_q;
    assign wake_sink_on  = wake_en_q;

    // ------------------------------------------------------------
    // last-read latch and change flag
    // ------------------------------------------------------------
    // only power-on clears the latch; master clear and brownout leave it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            last_read_q <= '0;
        end else if (port_access) begin
            last_read_q <= pins.pin_in & pin_digital;
        end
    end

    // port access in the same cycle takes priority; a change then is missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (|mismatch && !port_access) begin
            flag_q <= 1'b1;
        end else if (wr_en && paddr == OFS_CONTROL && !pwdata[CTL_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    assign change_irq = flag_q && gie_q;
    assign wake_req   = flag_q && sleeping;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    assign pullup_view = crystal_osc_mode ? (pullup_q | OSC_FORCE_MASK) : pullup_q;
    assign change_view = crystal_osc_mode ? (change_en_q | OSC_FORCE_MASK) : change_en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_ANALOG:    prdata <= {24'h00_0000, analog_q};
                OFS_PULLUP:    prdata <= {24'h00_0000, pullup_view};
                OFS_CHANGE_EN: prdata <= {24'h00_0000, change_view};
                OFS_CONTROL:   prdata <= {28'h000_0000, flag_q, gie_q, wake_en_q, pullup_dis_q};
                OFS_PORT:      prdata <= {26'h000_0000, pins.pin_in & pin_digital};
                OFS_STATUS:    prdata <= {26'h000_0000, mismatch};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_mismatch;
        (|mismatch) && !port_access;
    endsequence

    chk_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        s_mismatch |=> flag_q) else $error("flag not set after mismatch");
    chk_output_pullup: assert property (@(posedge pclk) disable iff (!presetn)
        !pins.dir_in[1] |-> !pullup_on[1]) else $error("pullup on output pin");
    chk_global_dis: assert property (@(posedge pclk) disable iff (!presetn)
        pullup_dis_q |-> (pullup_on & 6'h37) == 6'h00) else $error("pullup with global disable");
    chk_analog_gate: assert property (@(posedge pclk) disable iff (!presetn)
        analog_q[0] |-> !mismatch[0] && !pullup_on[0]) else $error("analog pin not gated");
    chk_irq_gie: assert property (@(posedge pclk) disable iff (!presetn)
        change_irq |-> gie_q && flag_q) else $error("irq without global enable");
    chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        flag_q && !(wr_en && paddr == OFS_CONTROL) |=> flag_q) else $error("flag dropped");
    chk_wake_sink: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(wake_en_q) |-> wake_sink_on) else $error("sink not on");
    chk_wake_req: assert property (@(posedge pclk) disable iff (!presetn)
        (s_mismatch and sleeping) |=> wake_req || !sleeping) else $error("no wake");
    chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        change_en_q[7:6] == 2'b00 && pullup_q[3] == 1'b0) else $error("reserved bits set");

    // ------------------------------------------------------------
    // check sequences
    // ------------------------------------------------------------
    sequence s_wr_at(logic [7:0] a);
        wr_en && paddr == a;
    endsequence

    sequence s_rd_setup(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    sequence s_clear_req;
        wr_en && paddr == OFS_CONTROL && !pwdata[CTL_FLAG];
    endsequence

    sequence s_reset_exit;
        $rose(presetn);
    endsequence

    // ------------------------------------------------------------
    // checks: reset values and register writes
    // ------------------------------------------------------------
    chk_rst_analog: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reset_exit |-> analog_q == ANALOG_RST)
        else $error("analog select reset value");
    chk_rst_pullup: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reset_exit |-> pullup_q == PULLUP_RST)
        else $error("pull-up enable reset value");
    chk_rst_change: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reset_exit |-> change_en_q == CHANGE_EN_RST)
        else $error("change enable reset value");
    chk_rst_global: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reset_exit |-> pullup_dis_q)
        else $error("global pull-up disable not set");
    chk_analog_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_at(OFS_ANALOG) |=> analog_q == $past(pwdata[7:0]))
        else $error("analog select write lost");
    chk_pullup_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_at(OFS_PULLUP) |=> pullup_q == ($past(pwdata[7:0]) & PULLUP_MASK))
        else $error("pull-up enable write wrong");
    chk_change_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_at(OFS_CHANGE_EN) |=> change_en_q == ($past(pwdata[7:0]) & CHANGE_EN_MASK))
        else $error("change enable write wrong");
    chk_pullup_gap: assert property (
        @(posedge pclk) disable iff (!presetn)
        pullup_q[7:6] == 2'b00)
        else $error("pull-up upper bits set");

    // ------------------------------------------------------------
    // checks: pull-ups and analog gating
    // ------------------------------------------------------------
    chk_io_pullup: assert property (
        @(posedge pclk) disable iff (!presetn)
        pullup_on[INPUT_ONLY_IDX] == master_clear_mode)
        else $error("input-only pull-up wrong");
    chk_pullup_enable: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pullup_q[0] |-> !pullup_on[0])
        else $error("pull-up on without enable");
    chk_dir_all: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pullup_on & ~pins.dir_in & 6'h37) == 6'h00)
        else $error("pull-up on an output pin");
    chk_analog_pullup: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pullup_on & analog_q[5:0] & 6'h37) == 6'h00)
        else $error("pull-up on an analog pin");
    chk_analog_change: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mismatch & analog_q[5:0]) == 6'h00)
        else $error("change seen on an analog pin");
    chk_digital_en: assert property (
        @(posedge pclk) disable iff (!presetn)
        digital_in_en == ~analog_q[5:0])
        else $error("digital input not gated");
    chk_analog_port: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(OFS_PORT) |=> (prdata[5:0] & $past(analog_q[5:0])) == 6'h00)
        else $error("analog pin read as one");

    // ------------------------------------------------------------
    // checks: latch and change flag
    // ------------------------------------------------------------
    chk_enable_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mismatch & ~change_en_q[5:0]) == 6'h00)
        else $error("change seen on a disabled pin");
    chk_latch_load: assert property (
        @(posedge pclk) disable iff (!por_n)
        port_access |=> last_read_q == $past(pins.pin_in & pin_digital))
        else $error("last-read latch not loaded");
    chk_latch_keep: assert property (
        @(posedge pclk) disable iff (!por_n)
        !presetn && !port_access |=> $stable(last_read_q))
        else $error("last-read latch lost in reset");
    chk_master_clear_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reset_exit ##0 s_mismatch |=> flag_q)
        else $error("flag not set after reset");
    chk_flag_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_clear_req ##0 (mismatch == 6'h00) |=> !flag_q)
        else $error("flag clear ignored");
    chk_clear_lost: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_clear_req and s_mismatch) |=> flag_q)
        else $error("clear beat a live mismatch");
    chk_port_miss: assert property (
        @(posedge pclk) disable iff (!presetn)
        port_access && !flag_q |=> !flag_q)
        else $error("flag set during port access");
    chk_flag_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(flag_q) |-> $past(|mismatch))
        else $error("flag set without mismatch");
    chk_status_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(OFS_STATUS) |=> prdata[5:0] == $past(mismatch))
        else $error("status read wrong");

    // ------------------------------------------------------------
    // checks: read views, interrupt and wake
    // ------------------------------------------------------------
    chk_upper_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(OFS_CHANGE_EN) |=> prdata[31:6] == 26'h000_0000)
        else $error("change enable upper bits read");
    chk_osc_pullup: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(OFS_PULLUP) ##0 crystal_osc_mode |=> prdata[5:4] == 2'b11)
        else $error("oscillator pins not forced");
    chk_osc_change: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_setup(OFS_CHANGE_EN) ##0 crystal_osc_mode |=> prdata[5:4] == 2'b11)
        else $error("oscillator enables not forced");
    chk_irq_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        flag_q && gie_q |-> change_irq)
        else $error("irq missing with global enable");
    chk_sink_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_at(OFS_CONTROL) |=> wake_sink_on == $past(pwdata[CTL_WAKE_EN]))
        else $error("sink does not follow enable");
    chk_wake_sleep: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake_req |-> sleeping && flag_q)
        else $error("wake while awake");

endmodule

// ===== pin_env_model.sv
/*
 * pin side model: outside drivers, weak pull-ups, rc network on pin zero
 * assumes the bench chooses which pins are driven from outside
 */
`timescale 1ns/100ps
module pin_env_model (
    // clock
    input  wire logic                               pclk,
    // bench side
    input  wire logic [port_aux_pkg::PIN_COUNT-1:0] ext_val,
    input  wire logic [port_aux_pkg::PIN_COUNT-1:0] ext_en,
    // device side
    input  wire logic [port_aux_pkg::PIN_COUNT-1:0] pullup_on,
    input  wire logic                               wake_sink_on,
    output logic      [port_aux_pkg::PIN_COUNT-1:0] lvl
);
    import port_aux_pkg::*;
    logic [3:0] cap_q = 4'h0;
    logic       flip_q = 1'b0;
    // floating pins other than pin zero toggle so a stale level never passes
    always_ff @(posedge pclk) begin
        flip_q <= ~flip_q;
        if (ext_en[0]) cap_q <= ext_val[0] ? 4'hF : 4'h0;
        else if (wake_sink_on && cap_q != 4'h0) cap_q <= cap_q - 4'h1;
    end
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (ext_en[i]) lvl[i] = ext_val[i];
            else if (pullup_on[i]) lvl[i] = 1'b1;
            else lvl[i] = flip_q;
        end
        if (!ext_en[0]) lvl[0] = (cap_q > 4'h5);
    end
endmodule

// ===== test_port_pullup_change_wake.sv
/*
 * self-checking bench for the port auxiliary block
 * assumes the pin model supplies the pin levels
 */
`timescale 1ns/100ps
module test_port_pullup_change_wake;
    import port_aux_pkg::*;
    logic        pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, err, mcm = 0, xtal = 0, sleeping = 0, sink, irq, wake;
    logic [5:0]  dir = 6'h3F, ext_val = 6'h00, ext_en = 6'h3F, lvl, pu, din;
    logic [7:0]  ana;
    pin_side_t   pins;
    int          fails = 0, n_checks = 0, cyc = 0;
    assign pins = '{pin_in: lvl, dir_in: dir};
    always #25 pclk = ~pclk;
    port_pullup_change_wake port_pullup_change_wake_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_n(por_n), .master_clear_mode(mcm), .crystal_osc_mode(xtal),
        .sleeping(sleeping), .pins(pins), .pullup_on(pu), .digital_in_en(din), .analog_sel(ana),
        .wake_sink_on(sink), .change_irq(irq), .wake_req(wake));
    pin_env_model pin_env_model_i (.pclk(pclk), .ext_val(ext_val), .ext_en(ext_en), .pullup_on(pu),
        .wake_sink_on(sink), .lvl(lvl));
    task automatic finish_test();
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // -----------------------------------------------------------------
    // apb master: setup, access until pready, then release
    // -----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, r, exp);
    endtask
    task automatic rst(input logic por);
        presetn <= 1'b0;
        por_n <= ~por;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        rst(1'b1);
        rd("analog", OFS_ANALOG, 32'hFF);
        rd("pullup", OFS_PULLUP, 32'h37);
        rd("chg_en", OFS_CHANGE_EN, 32'h0);
        rd("control", OFS_CONTROL, 32'h1);
        wr(OFS_PULLUP, 32'hFFFF_FFFF);
        wr(OFS_CHANGE_EN, 32'hFFFF_FFFF);
        rd("pullup_w", OFS_PULLUP, 32'h37);
        rd("chg_en_w", OFS_CHANGE_EN, 32'h3F);
        wr(OFS_PULLUP, 32'h0);
        wr(OFS_CHANGE_EN, 32'h0);
        xtal <= 1'b1;
        rd("pullup_x", OFS_PULLUP, 32'h30);
        rd("chg_en_x", OFS_CHANGE_EN, 32'h30);
        xtal <= 1'b0;
        rd("unmapped", 8'h18, 32'h0);
        chk("slverr", err, 32'h1);
        wr(OFS_PULLUP, 32'h37);
        wr(OFS_ANALOG, 32'h0);
        wr(OFS_CONTROL, 32'h0);
        chk("pu_on", pu, 32'h37);
        mcm <= 1'b1;
        dir <= 6'h3D;
        @(posedge pclk);
        chk("pu_dir", pu, 32'h3D);
        wr(OFS_ANALOG, 32'h04);
        chk("pu_ana", pu, 32'h39);
        chk("din_en", din, 32'h3B);
        chk("ana_sel", ana, 32'h04);
        wr(OFS_CONTROL, 32'h1);
        chk("pu_global", pu, 32'h08);
        mcm <= 1'b0;
        dir <= 6'h3F;
        wr(OFS_ANALOG, 32'h0);
        wr(OFS_CHANGE_EN, 32'h3F);
        ext_val <= 6'h2A;
        rd("port", OFS_PORT, 32'h2A);
        wr(OFS_CONTROL, 32'h4);
        rd("no_flag", OFS_CONTROL, 32'h4);
        ext_val <= 6'h28;
        repeat (2) @(posedge pclk);
        chk("irq", irq, 32'h1);
        wr(OFS_CONTROL, 32'h4);
        rd("flag_held", OFS_CONTROL, 32'hC);
        rd("status", OFS_STATUS, 32'h2);
        rd("port2", OFS_PORT, 32'h28);
        wr(OFS_CONTROL, 32'h4);
        rd("flag_clr", OFS_CONTROL, 32'h4);
        ext_val <= 6'h29;
        wr(OFS_CONTROL, 32'h0);
        chk("irq_gie", irq, 32'h0);
        sleeping <= 1'b1;
        @(posedge pclk);
        chk("wake", wake, 32'h1);
        sleeping <= 1'b0;
        rd("port3", OFS_PORT, 32'h29);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CHANGE_EN, 32'h3E);
        ext_val <= 6'h28;
        wr(OFS_ANALOG, 32'h2);
        ext_val <= 6'h2A;
        rd("masked", OFS_CONTROL, 32'h0);
        rd("port4", OFS_PORT, 32'h28);
        ext_val <= 6'h00;
        rst(1'b0);
        wr(OFS_ANALOG, 32'h0);
        wr(OFS_CHANGE_EN, 32'h3F);
        rd("kept", OFS_CONTROL, 32'h9);
        rst(1'b1);
        wr(OFS_ANALOG, 32'h0);
        wr(OFS_CHANGE_EN, 32'h3F);
        rd("por", OFS_CONTROL, 32'h1);
        ext_val <= 6'h01;
        dir <= 6'h3E;
        wr(OFS_CHANGE_EN, 32'h01);
        dir <= 6'h3F;
        rd("port5", OFS_PORT, 32'h1);
        wr(OFS_CONTROL, 32'h7);
        chk("sink", sink, 32'h1);
        ext_en <= 6'h3E;
        sleeping <= 1'b1;
        for (int i = 0; i < 40 && wake !== 1'b1; i++) @(posedge pclk);
        chk("wake_ulp", wake, 32'h1);
        chk("vector", irq, 32'h1);
        finish_test();
    end
endmodule
